/* pkg/fto_pkg.sv */
// Purpose: Shared constants for the fault turn-off and propagation block
// Assumes: 100 MHz clock, 8-bit register port
// Notes:   Style codes double as the codes sent on the fault line
package fto_pkg;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_PERIOD_NS  = 10;
	localparam int RETRY_MS       = 130;
	localparam int RETRY_CYCLES   = RETRY_MS * 1000000 / CLK_PERIOD_NS;
	localparam int OK_SLOT_NS     = 1000;
	localparam int OK_SLOT_CYCLES = OK_SLOT_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [7:0] ADDR_LATCH_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_PROP_CONFIG  = 8'h02;
	localparam logic [7:0] ADDR_STYLE_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_FAULT_FLAGS  = 8'h16;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0] RST_LATCH_CONFIG = 8'h43;
	localparam logic [7:0] RST_PROP_CONFIG  = 8'h3F;
	localparam logic [5:0] RST_STYLE_CONFIG = 6'h20;
	localparam logic [5:1] RST_FAULT_FLAGS  = 5'h1F;

	// ==========================================================
	// Field positions (flags, latch and propagate share them)
	// ==========================================================
	localparam int BIT_WARN_THERMAL = 7;
	localparam int BIT_WARN_WINDOW  = 6;
	localparam int BIT_RAMP         = 5;
	localparam int BIT_THERMAL      = 4;
	localparam int BIT_CURRENT      = 3;
	localparam int BIT_LOW_V        = 2;
	localparam int BIT_EXCESS_V     = 1;
	localparam int BIT_PHASE_RSVD   = 0;
	localparam int BIT_RAMP_ENABLE  = 7;
	localparam int PROP_WIDTH       = 6;

	// Style fields in the style register
	localparam int STY_THERMAL_LSB  = 0;
	localparam int STY_LOW_V_LSB    = 2;
	localparam int STY_EXCESS_V_LSB = 4;

	// ==========================================================
	// Turn-off styles
	// ==========================================================
	localparam logic [1:0] STYLE_SEQ  = 2'h0;
	localparam logic [1:0] STYLE_CRIT = 2'h1;
	localparam logic [1:0] STYLE_EMER = 2'h2;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_BIT1, TX_BIT0, TX_HOLD
	} fto_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_BIT1, RX_BIT0, RX_OFF
	} fto_rx_e;

endpackage : fto_pkg

/* rtl/fto_fault_turnoff.sv */
// Purpose: Fault turn-off styles, fault flags and fault-line propagation
// Assumes: Fault inputs are levels synchronous to clk
// Notes:   Fault line is open drain; okIn is the resolved wire level
//
// Operation
// - Sequenced style requests normal ramp-down shutdown
// - Critical style turns both switches off
// - Emergency: upper off, lower on together
// - Style chosen per thermal, low, excess voltage
// - Fault flags register at 0x16 holds status
// - Writing one clears a latched fault bit
// - Propagating fault pulls fault line low
// - Low fault line starts same-style turn-off; this block runs critical until the two code slots are decoded
// - Turn-off type coded in the two slots after the falling edge's start slot
// - Propagated fault turns off healthy regulators
// - Propagate only fault types enabled for it
// - Propagation enables readable and writable register
// - Active fault reads zero, inactive one
// - Non-latching retries every 130 ms
// - Propagation enable bit positions, 7:6 zero
// - Latch config selects latching per type
`timescale 1ns/10ps
`default_nettype none

module fto_fault_turnoff
	import fto_pkg::*;
#(
	parameter int RETRY_COUNT = RETRY_CYCLES,
	parameter int SLOT_COUNT  = OK_SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Protection conditions
	input  wire logic       thermalWarning,
	input  wire logic       outputInWindowWarning,
	input  wire logic       rampDeviationFault,
	input  wire logic       thermalFault,
	input  wire logic       excessCurrentFault,
	input  wire logic       lowVoltageFault,
	input  wire logic       excessVoltageError,
	// Register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrEn,
	input  wire logic       regRdEn,
	output logic      [7:0] regRdData_q,
	// Shared fault line
	input  wire logic       okIn,
	output logic            okOut,
	output logic            okOe,
	// Power stage control
	output logic            seqOffReq_q,
	output logic            upperForceOff_q,
	output logic            lowerForceOff_q,
	output logic            lowerForceOn_q
);

	// ==========================================================
	// Declarations
	// ==========================================================
	logic [7:0]      latchConfig_q;
	logic [5:0]      propConfig_q;
	logic [5:0]      styleConfig_q;
	logic [5:1]      flags_q;
	logic [5:1]      cond;
	logic [5:1]      newFault;
	logic [1:0]      newStyle;
	logic            newProp;
	logic            offActive_q;
	logic [1:0]      ownStyle_q;
	logic [31:0]     retryCnt_q;
	logic            retryTick;
	logic            flagWrite;
	fto_tx_e         txState_q;
	logic [31:0]     txCnt_q;
	logic [1:0]      txCode_q;
	logic            txSlotEnd;
	fto_rx_e         rxState_q;
	logic [31:0]     rxCnt_q;
	logic [1:0]      rxCode_q;
	logic            okPrev_q;
	logic            rxSlotEnd;
	logic            rxMid;
	logic            rxActive;
	logic            offNow;
	logic [1:0]      effStyle;

	// Pick the harsher of two styles
	function automatic logic [1:0] harsher(input logic [1:0] a, input logic [1:0] b);
		return (a == STYLE_EMER || b == STYLE_EMER) ? STYLE_EMER :
		       (a == STYLE_CRIT || b == STYLE_CRIT) ? STYLE_CRIT : STYLE_SEQ;
	endfunction : harsher

	// ==========================================================
	// Fault detection
	// ==========================================================
	// Condition vector; ramp fault gated by its enable
	assign cond[BIT_RAMP]     = rampDeviationFault & latchConfig_q[BIT_RAMP_ENABLE];
	assign cond[BIT_THERMAL]  = thermalFault;
	assign cond[BIT_CURRENT]  = excessCurrentFault;
	assign cond[BIT_LOW_V]    = lowVoltageFault;
	assign cond[BIT_EXCESS_V] = excessVoltageError;

	// Event only where the flag still reads inactive
	assign newFault = cond & flags_q;

	always_comb begin
		newStyle = STYLE_SEQ;
		if (newFault[BIT_RAMP] || newFault[BIT_CURRENT]) begin
			newStyle = STYLE_CRIT;
		end
		if (newFault[BIT_THERMAL]) begin
			newStyle = harsher(newStyle, styleConfig_q[STY_THERMAL_LSB +: 2]);
		end
		if (newFault[BIT_LOW_V]) begin
			newStyle = harsher(newStyle, styleConfig_q[STY_LOW_V_LSB +: 2]);
		end
		if (newFault[BIT_EXCESS_V]) begin
			newStyle = harsher(newStyle, styleConfig_q[STY_EXCESS_V_LSB +: 2]);
		end
	end

	assign newProp = |(newFault & propConfig_q[5:1]);

	assign flagWrite = regWrEn && (regAddr == ADDR_FAULT_FLAGS);

	// ==========================================================
	// Registers
	// ==========================================================
	// latch config; propagation config; style config
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			latchConfig_q <= RST_LATCH_CONFIG;
			propConfig_q  <= RST_PROP_CONFIG[5:0];
			styleConfig_q <= RST_STYLE_CONFIG;
		end else if (regWrEn) begin
			case (regAddr)
				ADDR_LATCH_CONFIG: latchConfig_q <= regWrData;
				ADDR_PROP_CONFIG:  propConfig_q  <= regWrData[5:0];
				ADDR_STYLE_CONFIG: styleConfig_q <= regWrData[5:0];
				default: ;
			endcase
		end
	end

	// flags low while active; set wins over clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_q <= RST_FAULT_FLAGS;
		end else begin
			for (int i = 1; i <= 5; i++) begin
				if (cond[i]) begin
					flags_q[i] <= 1'b0;
				end else if (flagWrite && regWrData[i]) begin
					flags_q[i] <= 1'b1;
				end else if (retryTick && !latchConfig_q[i]) begin
					flags_q[i] <= 1'b1;
				end
			end
		end
	end

	// read mux, one cycle after the strobe
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData_q <= 8'h00;
		end else if (regRdEn) begin
			case (regAddr)
				ADDR_LATCH_CONFIG: regRdData_q <= latchConfig_q;
				ADDR_PROP_CONFIG:  regRdData_q <= {2'b00, propConfig_q};
				ADDR_STYLE_CONFIG: regRdData_q <= {2'b00, styleConfig_q};
				ADDR_FAULT_FLAGS:  regRdData_q <= {~thermalWarning, ~outputInWindowWarning, flags_q, 1'b1};
				default:           regRdData_q <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Own shutdown and retry
	// ==========================================================
	// Off on a new fault; a tick ends it once every flag is or becomes clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			offActive_q <= 1'b0;
			ownStyle_q  <= STYLE_SEQ;
		end else if (|newFault) begin
			offActive_q <= 1'b1;
			ownStyle_q  <= offActive_q ? harsher(ownStyle_q, newStyle) : newStyle;
		end else if (retryTick && (&(flags_q | (~latchConfig_q[5:1] & ~cond)))) begin
			offActive_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			retryCnt_q <= 32'h0;
		end else begin
			retryCnt_q <= (!offActive_q || retryTick) ? 32'h0 : retryCnt_q + 32'h1;
		end
	end

	assign retryTick = offActive_q && (retryCnt_q == 32'(RETRY_COUNT - 1));

	// ==========================================================
	// Fault line transmitter
	// ==========================================================
	assign txSlotEnd = (txCnt_q == 32'(SLOT_COUNT - 1));

	// low start slot, two code slots, then hold
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			txState_q <= TX_IDLE;
			txCnt_q   <= 32'h0;
			txCode_q  <= STYLE_SEQ;
		end else begin
			txCnt_q <= (txState_q == TX_IDLE || txSlotEnd) ? 32'h0 : txCnt_q + 32'h1;
			case (txState_q)
				TX_IDLE: begin
					if (newProp && rxState_q == RX_IDLE) begin
						txState_q <= TX_START;
						txCode_q  <= newStyle;
					end
				end
				TX_START: if (txSlotEnd) txState_q <= TX_BIT1;
				TX_BIT1:  if (txSlotEnd) txState_q <= TX_BIT0;
				TX_BIT0:  if (txSlotEnd) txState_q <= TX_HOLD;
				TX_HOLD:  if (!offActive_q) txState_q <= TX_IDLE;
				default: txState_q <= TX_IDLE;
			endcase
		end
	end

	// open drain, enable high only while pulling low
	assign okOut = 1'b0;
	always_comb begin
		case (txState_q)
			TX_START, TX_HOLD: okOe = 1'b1;
			TX_BIT1:           okOe = !txCode_q[1];
			TX_BIT0:           okOe = !txCode_q[0];
			default:           okOe = 1'b0;
		endcase
	end

	// ==========================================================
	// Fault line receiver
	// ==========================================================
	assign rxSlotEnd = (rxCnt_q == 32'(SLOT_COUNT - 1));
	assign rxMid     = (rxCnt_q == 32'(SLOT_COUNT / 2));

	// decode type after a falling edge not our own
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxState_q <= RX_IDLE;
			rxCnt_q   <= 32'h0;
			rxCode_q  <= STYLE_SEQ;
			okPrev_q  <= 1'b1;
		end else begin
			okPrev_q <= okIn;
			rxCnt_q  <= (rxState_q == RX_IDLE || rxSlotEnd) ? 32'h0 : rxCnt_q + 32'h1;
			case (rxState_q)
				RX_IDLE: begin
					if (okPrev_q && !okIn && txState_q == TX_IDLE) begin
						rxState_q <= RX_START;
					end
				end
				RX_START: if (rxSlotEnd) rxState_q <= RX_BIT1;
				// Sample each code slot at its middle
				RX_BIT1: begin
					if (rxMid) rxCode_q[1] <= okIn;
					if (rxSlotEnd) rxState_q <= RX_BIT0;
				end
				RX_BIT0: begin
					if (rxMid) rxCode_q[0] <= okIn;
					if (rxSlotEnd) rxState_q <= RX_OFF;
				end
				// Stay off until line high for a whole slot; low restarts the count
				RX_OFF: begin
					if (okIn && rxSlotEnd) begin
						rxState_q <= RX_IDLE;
					end else if (!okIn) begin
						rxCnt_q <= 32'h0;
					end
				end
				default: rxState_q <= RX_IDLE;
			endcase
		end
	end

	// remote shutdown from the first falling edge
	assign rxActive = (rxState_q != RX_IDLE);

	// Unknown code treated as the harshest style
	assign effStyle = offActive_q ? ownStyle_q :
	                  (rxState_q != RX_OFF) ? STYLE_CRIT :
	                  (rxCode_q <= STYLE_EMER) ? rxCode_q : STYLE_EMER;

	assign offNow = offActive_q || rxActive;

	// ==========================================================
	// Power stage outputs
	// ==========================================================
	// map style onto switch controls
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			seqOffReq_q     <= 1'b0;
			upperForceOff_q <= 1'b0;
			lowerForceOff_q <= 1'b0;
			lowerForceOn_q  <= 1'b0;
		end else begin
			seqOffReq_q     <= offNow;
			upperForceOff_q <= offNow && (effStyle != STYLE_SEQ);
			lowerForceOff_q <= offNow && (effStyle == STYLE_CRIT);
			lowerForceOn_q  <= offNow && (effStyle == STYLE_EMER);
		end
	end

endmodule : fto_fault_turnoff

`default_nettype wire

/* sim/fto_fault_turnoff_properties.sv */
// Purpose: Port-level assertions for the fault turn-off block
// Assumes: One clock, reset active high
// Notes:   Bound to every instance of the block
`timescale 1ns/10ps
`default_nettype none

module fto_fault_turnoff_properties
	import fto_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       sys_rst,
	// Conditions and register port
	input wire logic       thermalWarning,
	input wire logic       excessCurrentFault,
	input wire logic [7:0] regAddr,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData_q,
	// Fault line and power stage
	input wire logic       okIn,
	input wire logic       okOe,
	input wire logic       seqOffReq_q,
	input wire logic       upperForceOff_q,
	input wire logic       lowerForceOff_q,
	input wire logic       lowerForceOn_q
);
	// Single domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Turn-off styles
	// ==========================================================
	seq_covers_all_a: assert property (upperForceOff_q |-> seqOffReq_q)
		else $error("Forced switch state without shutdown request");
	crit_both_off_a: assert property (lowerForceOff_q |-> upperForceOff_q && !lowerForceOn_q)
		else $error("Critical turn-off left a switch on");
	emer_low_on_a: assert property (lowerForceOn_q |-> upperForceOff_q && !lowerForceOff_q)
		else $error("Emergency turn-off switch mix wrong");
	current_is_crit_a: assert property ($rose(excessCurrentFault) && !seqOffReq_q
		|-> ##[1:3] (upperForceOff_q && lowerForceOff_q)) else $error("Current fault not critical");

	// ==========================================================
	// Fault line
	// ==========================================================
	pull_means_off_a: assert property ($rose(okOe) |-> ##[0:2] seqOffReq_q)
		else $error("Fault line pulled without shutdown");
	remote_starts_off_a: assert property ($fell(okIn) && !okOe && !seqOffReq_q
		|-> ##[1:3] seqOffReq_q) else $error("Low fault line ignored");
	line_released_a: assert property ($fell(seqOffReq_q) |-> !okOe)
		else $error("Fault line held after shutdown ended");

	// ==========================================================
	// Register reads
	// ==========================================================
	flags_read_a: assert property (regRdEn && regAddr == ADDR_FAULT_FLAGS
		|=> regRdData_q[7] == !$past(thermalWarning) && regRdData_q[0]) else $error("Flags read wrong");
	prop_top_zero_a: assert property (regRdEn && regAddr == ADDR_PROP_CONFIG
		|=> regRdData_q[7:6] == 2'b00) else $error("Propagation top bits not zero");
endmodule : fto_fault_turnoff_properties

bind fto_fault_turnoff fto_fault_turnoff_properties u_props (
	.clk(clk), .sys_rst(sys_rst), .thermalWarning(thermalWarning),
	.excessCurrentFault(excessCurrentFault), .regAddr(regAddr), .regRdEn(regRdEn),
	.regRdData_q(regRdData_q), .okIn(okIn), .okOe(okOe), .seqOffReq_q(seqOffReq_q),
	.upperForceOff_q(upperForceOff_q), .lowerForceOff_q(lowerForceOff_q), .lowerForceOn_q(lowerForceOn_q)
);
`default_nettype wire

/* sim/fto_line_peer.sv */
// Purpose: Peer regulator sending a coded pull on the fault line
// Assumes: Same slot length as the block under test
// Notes:   Released line goes to the pull-up level
`timescale 1ns/10ps
`default_nettype none

module fto_line_peer
	import fto_pkg::*;
#(
	parameter int SLOT = 8
) (
	// Clock
	input  wire logic       clk,
	// Frame request
	input  wire logic       go,
	input  wire logic [1:0] code,
	// Open-drain pull
	output logic            oe
);
	int n = 0;

	// Slot counter, idle while released
	always @(posedge clk) begin
		n <= go ? n + 1 : 0;
	end

	always_comb begin
		if (!go)
			oe = 1'b0;
		else if (n < SLOT)
			oe = 1'b1;
		else if (n < 2 * SLOT)
			oe = !code[1];
		else if (n < 3 * SLOT)
			oe = !code[0];
		else
			oe = 1'b1;
	end
endmodule : fto_line_peer
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the fault turn-off block
// Assumes: Shortened retry and slot counts
// Notes:   Fault line resolved here with a pull-up
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import fto_pkg::*;
;
	localparam int RETRY = 200;
	localparam int SLOT  = 8;

	logic       clk         = 1'b0;
	logic       sys_rst     = 1'b1;
	logic       warnHot     = 1'b0;
	logic       warnWindow  = 1'b1;
	logic       faultRamp   = 1'b0;
	logic       faultHot    = 1'b0;
	logic       faultCurr   = 1'b0;
	logic       faultLowV   = 1'b0;
	logic       faultHighV  = 1'b0;
	logic       wrEn        = 1'b0;
	logic       rdEn        = 1'b0;
	logic       peerGo      = 1'b0;
	logic [1:0] peerCode    = 2'h0;
	logic [7:0] addr        = 8'h00;
	logic [7:0] wrData      = 8'h00;
	logic [7:0] rdData;
	logic       okOe;
	logic       okOutPin;
	logic       peerOe;
	logic       seqOff;
	logic       upOff;
	logic       loOff;
	logic       loOn;
	wire  logic okLine;
	wire  logic [7:0] outs;
	int         miscompares = 0;
	int         checksDone  = 0;
	int         cycles      = 0;
	int         n;

	assign okLine = (okOe ? okOutPin : 1'b1) && !peerOe;
	assign outs   = {4'h0, seqOff, upOff, loOff, loOn};

	always #5 clk = ~clk;

	fto_fault_turnoff #(.RETRY_COUNT(RETRY), .SLOT_COUNT(SLOT)) DUT (
		.clk(clk), .sys_rst(sys_rst), .thermalWarning(warnHot), .outputInWindowWarning(warnWindow),
		.rampDeviationFault(faultRamp), .thermalFault(faultHot), .excessCurrentFault(faultCurr),
		.lowVoltageFault(faultLowV), .excessVoltageError(faultHighV), .regAddr(addr), .regWrData(wrData),
		.regWrEn(wrEn), .regRdEn(rdEn), .regRdData_q(rdData), .okIn(okLine), .okOut(okOutPin),
		.okOe(okOe), .seqOffReq_q(seqOff), .upperForceOff_q(upOff), .lowerForceOff_q(loOff),
		.lowerForceOn_q(loOn));

	fto_line_peer #(.SLOT(SLOT)) u_peer (.clk(clk), .go(peerGo), .code(peerCode), .oe(peerOe));

	// ==========================================================
	// Tasks
	// ==========================================================
	task test_done();
		if (miscompares == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc

	task chk(input logic [7:0] s, input logic [7:0] e);
		checksDone++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wrData = d;
		wrEn = 1'b1;
		cyc(1);
		wrEn = 1'b0;
		cyc(1);
	endtask : wr

	task rd(input logic [7:0] a);
		addr = a;
		rdEn = 1'b1;
		cyc(1);
		rdEn = 1'b0;
		cyc(1);
	endtask : rd

	// Switch pattern per style
	function automatic logic [7:0] expOut(input logic [1:0] s);
		return (s == STYLE_SEQ) ? 8'h08 : (s == STYLE_CRIT) ? 8'h0E : 8'h0D;
	endfunction : expOut

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			test_done();
		end
	end

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		cyc(16);
		sys_rst = 1'b0;
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'hBF);
		rd(ADDR_LATCH_CONFIG);
		chk(rdData, RST_LATCH_CONFIG);
		rd(ADDR_STYLE_CONFIG);
		chk(rdData, 8'h20);
		rd(8'h06);
		chk(rdData, 8'h00);
		warnWindow = 1'b0;
		wr(ADDR_PROP_CONFIG, 8'hFF);
		rd(ADDR_PROP_CONFIG);
		chk(rdData, 8'h3F);
		// Own latched excess voltage in each style
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_STYLE_CONFIG, 8'(s << 4));
			faultHighV = 1'b1;
			for (n = 0; n < 20 && okOe !== 1'b1; n++) cyc(1);
			cyc(SLOT + SLOT / 2);
			chk({7'h0, okLine}, {7'h0, s[1]});
			cyc(SLOT);
			chk({7'h0, okLine}, {7'h0, s[0]});
			chk({7'h0, okOutPin}, 8'h00);
			chk(outs, expOut(2'(s)));
			faultHighV = 1'b0;
			rd(ADDR_FAULT_FLAGS);
			chk(rdData, 8'hFD);
			wr(ADDR_FAULT_FLAGS, 8'h02);
			rd(ADDR_FAULT_FLAGS);
			chk(rdData, 8'hFF);
			for (n = 0; n < 3 * RETRY && seqOff !== 1'b0; n++) cyc(1);
			chk({6'h0, okOe, seqOff}, 8'h00);
		end
		// Non-latching current fault held across one retry
		wr(ADDR_PROP_CONFIG, 8'h00);
		rd(ADDR_PROP_CONFIG);
		chk(rdData, 8'h00);
		faultCurr = 1'b1;
		cyc(4);
		chk(outs, 8'h0E);
		chk({7'h0, okOe}, 8'h00);
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'hF7);
		cyc(RETRY);
		faultCurr = 1'b0;
		for (n = RETRY + 6; n < 3 * RETRY && seqOff !== 1'b0; n++) cyc(1);
		chk(8'(n > 2 * RETRY - 5 && n < 2 * RETRY + 6), 8'h01);
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'hFF);
		// Thermal critical and low voltage emergency together
		wr(ADDR_STYLE_CONFIG, 8'h09);
		faultHot = 1'b1;
		faultLowV = 1'b1;
		cyc(4);
		chk(outs, expOut(STYLE_EMER));
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'hEB);
		faultHot = 1'b0;
		faultLowV = 1'b0;
		for (n = 0; n < 3 * RETRY && seqOff !== 1'b0; n++) cyc(1);
		chk({6'h0, okOe, seqOff}, 8'h00);
		// Ramp fault ignored until enabled, then critical
		faultRamp = 1'b1;
		cyc(4);
		chk(outs, 8'h00);
		wr(ADDR_LATCH_CONFIG, 8'hC3);
		cyc(2);
		chk(outs, expOut(STYLE_CRIT));
		faultRamp = 1'b0;
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'hDF);
		for (n = 0; n < 3 * RETRY && seqOff !== 1'b0; n++) cyc(1);
		chk({6'h0, okOe, seqOff}, 8'h00);
		// Remote pulls decoded by a healthy regulator
		warnHot = 1'b1;
		for (int s = 0; s < 3; s++) begin
			peerCode = 2'(s);
			peerGo = 1'b1;
			cyc(4);
			chk(outs, 8'h0E);
			cyc(4 * SLOT);
			chk(outs, expOut(2'(s)));
			peerGo = 1'b0;
			cyc(2 * SLOT);
			chk({6'h0, okOe, seqOff}, 8'h00);
		end
		rd(ADDR_FAULT_FLAGS);
		chk(rdData, 8'h7F);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
